// >>> csdp_consts.svh
/*
 * register indices, field positions, reset values and masks of the
 * status and dual pointer block.
 * assumes: included by bare name; byte address on the bus is 4 x index.
 */
`ifndef CSDP_CONSTS_SVH
`define CSDP_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define CSDP_IDX_STACK 8'h81
`define CSDP_IDX_PLO0  8'h82
`define CSDP_IDX_PHI0  8'h83
`define CSDP_IDX_PLO1  8'h84
`define CSDP_IDX_PHI1  8'h85
`define CSDP_IDX_CTRL  8'h86
`define CSDP_IDX_STAT  8'hd0

// ----------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------
`define CSDP_RST_STACK 8'h07
`define CSDP_RST_STAT  8'h00
`define CSDP_RST_CTRL  8'h00
`define CSDP_RST_PTR   16'h0000
`define CSDP_CTRL_MASK 8'hf9
`define CSDP_ZERO_WORD 32'h0000_0000

// ----------------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------------
`define CSDP_ST_CY  7
`define CSDP_ST_AC  6
`define CSDP_ST_BKH 4
`define CSDP_ST_BKL 3
`define CSDP_ST_OV  2
`define CSDP_ST_PAR 0

// ----------------------------------------------------------------------
// pointer control fields
// ----------------------------------------------------------------------
`define CSDP_CT_DN1 7
`define CSDP_CT_DN0 6
`define CSDP_CT_TGL 5
`define CSDP_CT_AU1 4
`define CSDP_CT_AU0 3
`define CSDP_CT_SEL 0

`endif

// >>> csdp_core.sv
/*
 * stack top, cpu status word and dual data pointer registers of the core,
 * reached by software over a classic wishbone slave.
 * assumes: cpu strobes are one-cycle pulses on i_clk; accumulator on i_acc.
 */
// How it works
// - stack top is 8 bits, resets to 07h, first push at 08h.
// - status word at index d0h, whole byte access, resets to zero.
// - carry bit 7 set on carry or borrow at top bit.
// - half carry bit 6 set on carry or borrow at bit 3.
// - bank bits 4 and 3 pick one of four 8-byte register banks.
// - parity bit 0 follows accumulator: 1 for odd count of ones.
// - two 16-bit pointers, each also reachable low and high byte.
// - pointer control at index 86h resets zero, bits 2 and 1 reserved.
// - choice bit 0 routes indirect moves to pointer zero or one.
// - auto step bit 3 moves pointer zero by one per indirect move while choice bit 0 picks it.
// - auto step bit 4 moves pointer one by one per indirect move while choice bit 0 picks it.
// - bit 6 picks decrement for pointer zero while it steps.
// - bit 7 picks decrement for pointer one while it steps.
// - toggle bit 5 flips the choice bit after each indirect move.
`include "csdp_consts.svh"

module csdp_core (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_wb_cyc,
	input  wire logic               i_wb_stb,
	input  wire logic               i_wb_we,
	input  wire logic [9:0]         i_wb_adr,
	input  wire logic [3:0]         i_wb_sel,
	input  wire logic [31:0]        i_wb_dat,
	output logic      [31:0]        o_wb_dat,
	output logic                    o_wb_ack,
	input  wire logic [7:0]         i_acc,
	input  wire logic               i_flag_upd,
	input  wire csdp_pkg::csdp_op_e i_op,
	input  wire logic [7:0]         i_opa,
	input  wire logic [7:0]         i_opb,
	input  wire logic               i_cin,
	input  wire logic               i_sp_wr,
	input  wire logic [7:0]         i_sp_val,
	input  wire logic               i_ind_move,
	input  wire logic               i_ptr_load,
	input  wire logic [15:0]        i_ptr_val,
	output logic      [7:0]         o_stack_top,
	output logic      [7:0]         o_status,
	output logic      [7:0]         o_ctrl,
	output logic      [4:0]         o_bank_base,
	output logic      [15:0]        o_ptr_zero,
	output logic      [15:0]        o_ptr_one,
	output logic      [15:0]        o_active_ptr
);
	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	logic [7:0]  idx;
	logic        req;
	logic        wr;
	logic [7:0]  wbyte;
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;

	assign idx   = i_wb_adr[9:2];
	assign req   = i_wb_cyc & i_wb_stb;
	// write lands on the edge at which the master sees ack
	assign wr    = req & i_wb_we & ack_r & i_wb_sel[0];
	assign wbyte = i_wb_dat[7:0];

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [7:0]  stack_r;
	logic [7:0]  stack_nxt;
	logic [7:0]  stat_r;
	logic [7:0]  stat_nxt;
	logic [7:0]  ctrl_r;
	logic [7:0]  ctrl_nxt;
	logic [4:0]  bank_r;
	logic [4:0]  bank_nxt;
	logic [15:0] act_r;
	logic [15:0] act_nxt;
	logic        f_cy;
	logic        f_ac;
	logic        f_ov;
	logic [1:0]  p_step;
	logic [1:0]  p_down;
	logic [1:0]  p_wlo;
	logic [1:0]  p_whi;
	logic [1:0]  p_load;
	logic [15:0] p_q [2];
	logic [15:0] p_n [2];

	csdp_flags u_flags (
		.i_op  (i_op),
		.i_a   (i_opa),
		.i_b   (i_opb),
		.i_cin (i_cin),
		.o_cy  (f_cy),
		.o_ac  (f_ac),
		.o_ov  (f_ov)
	);

	// ------------------------------------------------------------------
	// data pointers
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ptr
			assign p_wlo[g]  = wr && (idx == (`CSDP_IDX_PLO0 + 8'(2 * g)));
			assign p_whi[g]  = wr && (idx == (`CSDP_IDX_PHI0 + 8'(2 * g)));
			// word load goes to chosen pointer
			assign p_load[g] = i_ptr_load && (ctrl_r[`CSDP_CT_SEL] == 1'(g));
			assign p_step[g] = i_ind_move && (ctrl_r[`CSDP_CT_SEL] == 1'(g)) &&
				ctrl_r[`CSDP_CT_AU0 + g];
			assign p_down[g] = ctrl_r[`CSDP_CT_DN0 + g];
			csdp_ptr u_ptr (
				.i_clk      (i_clk),
				.i_rst      (i_rst),
				.i_wr_lo    (p_wlo[g]),
				.i_wr_hi    (p_whi[g]),
				.i_wdat     (wbyte),
				.i_load     (p_load[g]),
				.i_load_val (i_ptr_val),
				.i_step     (p_step[g]),
				.i_down     (p_down[g]),
				.o_ptr      (p_q[g]),
				.o_nxt      (p_n[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		stack_nxt = stack_r;
		stat_nxt  = stat_r;
		ctrl_nxt  = ctrl_r;
		if (wr && idx == `CSDP_IDX_STACK) begin
			stack_nxt = wbyte;
		end
		if (i_sp_wr) begin
			stack_nxt = i_sp_val;
		end
		if (wr && idx == `CSDP_IDX_STAT) begin
			stat_nxt = wbyte;
		end
		// hardware flag update wins over a bus write in the same cycle
		if (i_flag_upd) begin
			stat_nxt[`CSDP_ST_CY] = f_cy;
			stat_nxt[`CSDP_ST_AC] = f_ac;
			stat_nxt[`CSDP_ST_OV] = f_ov;
		end
		// parity tracks the accumulator every cycle
		stat_nxt[`CSDP_ST_PAR] = ^i_acc;
		if (wr && idx == `CSDP_IDX_CTRL) begin
			ctrl_nxt = wbyte & `CSDP_CTRL_MASK;
		end
		// flip after the move, on top of any write
		if (i_ind_move && ctrl_r[`CSDP_CT_TGL]) begin
			ctrl_nxt[`CSDP_CT_SEL] = ~ctrl_nxt[`CSDP_CT_SEL];
		end
		// bank base address from bank bits
		bank_nxt = {stat_nxt[`CSDP_ST_BKH:`CSDP_ST_BKL], 3'b000};
		act_nxt  = ctrl_nxt[`CSDP_CT_SEL] ? p_n[1] : p_n[0];
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			stack_r <= `CSDP_RST_STACK;
			stat_r  <= `CSDP_RST_STAT;
			ctrl_r  <= `CSDP_RST_CTRL;
			bank_r  <= 5'h00;
			act_r   <= `CSDP_RST_PTR;
		end else begin
			stack_r <= stack_nxt;
			stat_r  <= stat_nxt;
			ctrl_r  <= ctrl_nxt;
			bank_r  <= bank_nxt;
			act_r   <= act_nxt;
		end
	end

	// ------------------------------------------------------------------
	// bus answer
	// ------------------------------------------------------------------
	// unmapped indices answer with zero, writes there are dropped
	always_comb begin
		ack_nxt  = req & ~ack_r;
		rdat_nxt = rdat_r;
		if (req && !ack_r) begin
			rdat_nxt = `CSDP_ZERO_WORD;
			unique case (idx)
				`CSDP_IDX_STACK: rdat_nxt[7:0] = stack_r;
				`CSDP_IDX_PLO0:  rdat_nxt[7:0] = p_q[0][7:0];
				`CSDP_IDX_PHI0:  rdat_nxt[7:0] = p_q[0][15:8];
				`CSDP_IDX_PLO1:  rdat_nxt[7:0] = p_q[1][7:0];
				`CSDP_IDX_PHI1:  rdat_nxt[7:0] = p_q[1][15:8];
				`CSDP_IDX_CTRL:  rdat_nxt[7:0] = ctrl_r;
				`CSDP_IDX_STAT:  rdat_nxt[7:0] = stat_r;
				default:         rdat_nxt[7:0] = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_r  <= 1'b0;
			rdat_r <= `CSDP_ZERO_WORD;
		end else begin
			ack_r  <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	assign o_wb_ack     = ack_r;
	assign o_wb_dat     = rdat_r;
	assign o_stack_top  = stack_r;
	assign o_status     = stat_r;
	assign o_ctrl       = ctrl_r;
	assign o_bank_base  = bank_r;
	assign o_ptr_zero   = p_q[0];
	assign o_ptr_one    = p_q[1];
	assign o_active_ptr = act_r;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	logic ctrl_wr;
	logic p0_wr;
	assign ctrl_wr = wr && idx == `CSDP_IDX_CTRL;
	assign p0_wr   = p_wlo[0] | p_whi[0] | p_load[0];

	sequence s_step0;
		i_ind_move && ctrl_r[`CSDP_CT_AU0] && !ctrl_r[`CSDP_CT_SEL] && !p0_wr;
	endsequence

	sequence s_toggle;
		i_ind_move && ctrl_r[`CSDP_CT_TGL] && !ctrl_wr;
	endsequence

	property p_stack_rst;
		$fell(i_rst) |-> o_stack_top == `CSDP_RST_STACK;
	endproperty
	a_stack_rst: assert property (p_stack_rst) else $error("stack top reset value wrong");

	property p_stat_rst;
		$fell(i_rst) |-> o_status[7:1] == 7'h00;
	endproperty
	a_stat_rst: assert property (p_stat_rst) else $error("status reset not zero");

	property p_carry_add;
		i_flag_upd && i_op == csdp_pkg::CSDP_OP_ADD |=> o_status[`CSDP_ST_CY] ==
			(($past({1'b0, i_opa}) + $past({1'b0, i_opb}) + $past({8'h00, i_cin})) > 9'h0ff);
	endproperty
	a_carry_add: assert property (p_carry_add) else $error("carry after add wrong");

	property p_half_sub;
		i_flag_upd && i_op == csdp_pkg::CSDP_OP_SUB |=> o_status[`CSDP_ST_AC] ==
			({1'b0, $past(i_opa[3:0])} < ({1'b0, $past(i_opb[3:0])} + {4'h0, $past(i_cin)}));
	endproperty
	a_half_sub: assert property (p_half_sub) else $error("half borrow after subtract wrong");

	property p_bank;
		wr && idx == `CSDP_IDX_STAT |=> o_bank_base == {$past(wbyte[`CSDP_ST_BKH:`CSDP_ST_BKL]), 3'b000};
	endproperty
	a_bank: assert property (p_bank) else $error("bank base does not match bank bits");

	property p_parity;
		##1 o_status[`CSDP_ST_PAR] == ^$past(i_acc);
	endproperty
	a_parity: assert property (p_parity) else $error("parity does not follow accumulator");

	property p_reserved;
		##1 o_ctrl[2:1] == 2'b00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved control bits not zero");

	property p_route;
		##1 o_active_ptr == (o_ctrl[`CSDP_CT_SEL] ? o_ptr_one : o_ptr_zero);
	endproperty
	a_route: assert property (p_route) else $error("active pointer not the chosen one");

	property p_step0;
		s_step0 |=> o_ptr_zero == ($past(o_ctrl[`CSDP_CT_DN0]) ?
			$past(o_ptr_zero) - 16'h0001 : $past(o_ptr_zero) + 16'h0001);
	endproperty
	a_step0: assert property (p_step0) else $error("pointer zero step wrong");

	property p_idle1;
		!p_step[1] && !p_wlo[1] && !p_whi[1] && !p_load[1] |=> $stable(o_ptr_one);
	endproperty
	a_idle1: assert property (p_idle1) else $error("pointer one changed without cause");

	property p_toggle;
		s_toggle |=> o_ctrl[`CSDP_CT_SEL] != $past(o_ctrl[`CSDP_CT_SEL]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("choice bit did not flip");

	property p_ack;
		req && !ack_r |=> o_wb_ack ##1 !o_wb_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer not one cycle after request");
endmodule // csdp_core

// >>> csdp_flags.sv
/*
 * carry, half carry and signed wrap of one 8-bit add or subtract.
 * assumes: purely combinational, operands stable for the cycle.
 */
module csdp_flags (
	input  wire csdp_pkg::csdp_op_e i_op,
	input  wire logic [7:0]         i_a,
	input  wire logic [7:0]         i_b,
	input  wire logic               i_cin,
	output logic                    o_cy,
	output logic                    o_ac,
	output logic                    o_ov
);
	logic [8:0] res;
	logic [4:0] nib;
	logic       sub;

	always_comb begin
		sub = (i_op == csdp_pkg::CSDP_OP_SUB);
		if (sub) begin
			res = {1'b0, i_a} - {1'b0, i_b} - {8'h00, i_cin};
			nib = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, i_cin};
		end else begin
			res = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
			nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
		end
		// top bit out: carry on add, borrow on subtract
		o_cy = res[8];
		o_ac = nib[4];
		// wrap when sign of result leaves the operand sign range
		o_ov = ((i_a[7] ^ i_b[7]) == sub) && (res[7] != i_a[7]);
	end
endmodule // csdp_flags

// >>> csdp_pkg.sv
/*
 * types shared by the status and dual pointer block.
 * assumes: compiled before every other file of the block.
 */
package csdp_pkg;
	// ------------------------------------------------------------------
	// arithmetic kinds
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		CSDP_OP_ADD = 2'b01,
		CSDP_OP_SUB = 2'b10
	} csdp_op_e;
endpackage

// >>> csdp_ptr.sv
/*
 * one 16-bit data pointer with byte writes, word load and auto step.
 * assumes: strobes are one-cycle pulses on i_clk.
 */
`include "csdp_consts.svh"

module csdp_ptr (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_wr_lo,
	input  wire logic        i_wr_hi,
	input  wire logic [7:0]  i_wdat,
	input  wire logic        i_load,
	input  wire logic [15:0] i_load_val,
	input  wire logic        i_step,
	input  wire logic        i_down,
	output logic      [15:0] o_ptr,
	output logic      [15:0] o_nxt
);
	logic [15:0] ptr_r;
	logic [15:0] ptr_nxt;

	// step applies on top of any write in the same cycle
	always_comb begin
		ptr_nxt = ptr_r;
		if (i_load) begin
			ptr_nxt = i_load_val;
		end
		if (i_wr_lo) begin
			ptr_nxt[7:0] = i_wdat;
		end
		if (i_wr_hi) begin
			ptr_nxt[15:8] = i_wdat;
		end
		if (i_step) begin
			ptr_nxt = i_down ? ptr_nxt - 16'h0001 : ptr_nxt + 16'h0001;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ptr_r <= `CSDP_RST_PTR;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	assign o_ptr = ptr_r;
	assign o_nxt = ptr_nxt;
endmodule // csdp_ptr

// >>> csdp_tb.sv
/*
 * self-checking bench of the status and dual pointer block: bus reads and
 * writes, cpu strobes, flag updates and pointer stepping.
 * assumes: csdp_pkg compiled first; classic wishbone slave acks one cycle
 * after a taken request.
 */
`include "csdp_consts.svh"

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam int TMO = 3000;
	logic               i_clk;
	logic               i_rst;
	logic               i_wb_cyc;
	logic               i_wb_stb;
	logic               i_wb_we;
	logic [9:0]         i_wb_adr;
	logic [3:0]         i_wb_sel;
	logic [31:0]        i_wb_dat;
	logic [31:0]        o_wb_dat;
	logic               o_wb_ack;
	logic [7:0]         i_acc;
	logic               i_flag_upd;
	csdp_pkg::csdp_op_e i_op;
	logic [7:0]         i_opa;
	logic [7:0]         i_opb;
	logic               i_cin;
	logic               i_sp_wr;
	logic [7:0]         i_sp_val;
	logic               i_ind_move;
	logic               i_ptr_load;
	logic [15:0]        i_ptr_val;
	logic [7:0]         o_stack_top;
	logic [7:0]         o_status;
	logic [7:0]         o_ctrl;
	logic [4:0]         o_bank_base;
	logic [15:0]        o_ptr_zero;
	logic [15:0]        o_ptr_one;
	logic [15:0]        o_active_ptr;
	logic [31:0]        rd_q;
	logic [17:0]        tbl [6];
	logic [7:0]         sv;
	int                 err_count;
	int                 n_compared;
	int                 cycles = 0;

	csdp_core dut (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
		.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
		.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_acc(i_acc), .i_flag_upd(i_flag_upd),
		.i_op(i_op), .i_opa(i_opa), .i_opb(i_opb), .i_cin(i_cin), .i_sp_wr(i_sp_wr),
		.i_sp_val(i_sp_val), .i_ind_move(i_ind_move), .i_ptr_load(i_ptr_load),
		.i_ptr_val(i_ptr_val), .o_stack_top(o_stack_top), .o_status(o_status), .o_ctrl(o_ctrl),
		.o_bank_base(o_bank_base), .o_ptr_zero(o_ptr_zero), .o_ptr_one(o_ptr_one),
		.o_active_ptr(o_active_ptr));

	always #10 i_clk = ~i_clk;

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic finish_test();
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: value %h expected %h", $time, seen, exp);
		end
	endtask

	// one classic cycle; request held until ack is sampled high
	task automatic wb_req(input logic [7:0] idx, input logic we, input logic [7:0] d, input logic [3:0] sel);
		i_wb_cyc <= 1'b1;
		i_wb_stb <= 1'b1;
		i_wb_we  <= we;
		i_wb_adr <= {idx, 2'b00};
		i_wb_dat <= {24'h00_0000, d};
		i_wb_sel <= sel;
		do @(posedge i_clk); while (o_wb_ack !== 1'b1);
		rd_q = o_wb_dat;
		i_wb_cyc <= 1'b0;
		i_wb_stb <= 1'b0;
		i_wb_we  <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		wb_req(idx, 1'b1, d, 4'h1);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
		wb_req(idx, 1'b0, 8'h00, 4'h1);
		chk(rd_q, {24'h00_0000, e});
	endtask

	// strobe for one cycle, look one edge later when outputs have landed
	task automatic mv(input logic [15:0] e0, input logic [15:0] e1, input logic es);
		i_ind_move <= 1'b1;
		@(posedge i_clk);
		i_ind_move <= 1'b0;
		@(posedge i_clk);
		chk({16'h0000, o_ptr_zero}, {16'h0000, e0});
		chk({16'h0000, o_ptr_one}, {16'h0000, e1});
		chk({31'h0000_0000, o_ctrl[0]}, {31'h0000_0000, es});
		chk({16'h0000, o_active_ptr}, {16'h0000, es ? e1 : e0});
	endtask

	function automatic logic [1:0] flg(input logic [17:0] t);
		logic [8:0] r;
		logic [4:0] h;
		r = t[17] ? {1'b0, t[16:9]} - {1'b0, t[8:1]} - 9'(t[0]) : {1'b0, t[16:9]} + {1'b0, t[8:1]} + 9'(t[0]);
		h = t[17] ? {1'b0, t[12:9]} - {1'b0, t[4:1]} - 5'(t[0]) : {1'b0, t[12:9]} + {1'b0, t[4:1]} + 5'(t[0]);
		return {r[8], h[4]};
	endfunction

	// ------------------------------------------------------------------
	// hang guard
	// ------------------------------------------------------------------
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == TMO) begin
			err_count++;
			finish_test();
		end
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		{i_clk, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_acc, i_flag_upd} = '0;
		{i_opa, i_opb, i_cin, i_sp_wr, i_sp_val, i_ind_move, i_ptr_load, i_ptr_val} = '0;
		i_rst = 1'b1;
		i_wb_sel = 4'h1;
		i_op = csdp_pkg::CSDP_OP_ADD;
		err_count = 0;
		n_compared = 0;
		tbl = '{{1'b0, 8'h80, 8'h80, 1'b0}, {1'b0, 8'h0f, 8'h01, 1'b0}, {1'b0, 8'hfe, 8'h01, 1'b1},
			{1'b1, 8'h00, 8'h01, 1'b0}, {1'b1, 8'h10, 8'h01, 1'b0}, {1'b1, 8'h55, 8'h54, 1'b1}};
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rdchk(`CSDP_IDX_STACK, 8'h07);
		rdchk(`CSDP_IDX_STAT, 8'h00);
		rdchk(`CSDP_IDX_CTRL, 8'h00);
		chk({o_ptr_zero, o_ptr_one}, 32'h0000_0000);
		wr(`CSDP_IDX_STACK, 8'h5a);
		wb_req(`CSDP_IDX_STACK, 1'b1, 8'ha5, 4'he);
		rdchk(`CSDP_IDX_STACK, 8'h5a);
		i_sp_val <= 8'h08;
		i_sp_wr <= 1'b1;
		@(posedge i_clk);
		i_sp_wr <= 1'b0;
		@(posedge i_clk);
		chk({24'h00_0000, o_stack_top}, 32'h0000_0008);
		// unmapped place neither answers data nor disturbs the control byte
		wr(8'h80, 8'h3c);
		rdchk(8'h80, 8'h00);
		rdchk(`CSDP_IDX_CTRL, 8'h00);
		wr(`CSDP_IDX_CTRL, 8'hff);
		rdchk(`CSDP_IDX_CTRL, 8'hf9);
		wr(`CSDP_IDX_CTRL, 8'h00);
		for (int b = 0; b < 4; b++) begin
			i_acc <= {6'h00, 2'(b)};
			sv = {3'b001, 2'(b), 3'b010};
			wr(`CSDP_IDX_STAT, sv);
			rdchk(`CSDP_IDX_STAT, {sv[7:1], ^(2'(b))});
			chk({27'h000_0000, o_bank_base}, {27'h000_0000, 2'(b), 3'b000});
		end
		for (int k = 0; k < 6; k++) begin
			i_op <= tbl[k][17] ? csdp_pkg::CSDP_OP_SUB : csdp_pkg::CSDP_OP_ADD;
			{i_opa, i_opb, i_cin} <= tbl[k][16:0];
			i_flag_upd <= 1'b1;
			@(posedge i_clk);
			i_flag_upd <= 1'b0;
			@(posedge i_clk);
			chk({30'h0000_0000, o_status[7:6]}, {30'h0000_0000, flg(tbl[k])});
		end
		wr(`CSDP_IDX_PLO0, 8'h34);
		wr(`CSDP_IDX_PHI0, 8'h12);
		wr(`CSDP_IDX_PLO1, 8'hff);
		wr(`CSDP_IDX_PHI1, 8'hff);
		rdchk(`CSDP_IDX_PHI0, 8'h12);
		chk({o_ptr_zero, o_ptr_one}, 32'h1234_ffff);
		mv(16'h1234, 16'hffff, 1'b0);
		wr(`CSDP_IDX_CTRL, 8'h08);
		mv(16'h1235, 16'hffff, 1'b0);
		wr(`CSDP_IDX_CTRL, 8'h48);
		mv(16'h1234, 16'hffff, 1'b0);
		wr(`CSDP_IDX_CTRL, 8'h11);
		mv(16'h1234, 16'h0000, 1'b1);
		wr(`CSDP_IDX_CTRL, 8'h91);
		mv(16'h1234, 16'hffff, 1'b1);
		wr(`CSDP_IDX_CTRL, 8'h41);
		mv(16'h1234, 16'hffff, 1'b1);
		// step the pointer just used, then the choice flips to the other
		wr(`CSDP_IDX_CTRL, 8'h38);
		mv(16'h1235, 16'hffff, 1'b1);
		mv(16'h1235, 16'h0000, 1'b0);
		i_ptr_val <= 16'hbeef;
		i_ptr_load <= 1'b1;
		@(posedge i_clk);
		i_ptr_load <= 1'b0;
		@(posedge i_clk);
		rdchk(`CSDP_IDX_PLO0, 8'hef);
		rdchk(`CSDP_IDX_PHI0, 8'hbe);
		// pointer one bytes read back apart, not swapped
		wr(`CSDP_IDX_PHI1, 8'h5a);
		rdchk(`CSDP_IDX_PHI1, 8'h5a);
		rdchk(`CSDP_IDX_PLO1, 8'h00);
		// second reset in mid-run
		i_rst <= 1'b1;
		@(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk({o_stack_top, o_ctrl, o_ptr_zero}, 32'h0700_0000);
		chk({o_ptr_one, o_status, o_bank_base, 3'b000}, 32'h0000_0000);
		finish_test();
	end
endmodule // testbench
